//--- logic/rof_formatter.sv
// Reading output formatter with AXI4-Lite control and reading store
// Notes on behaviour
// [RQ1] Display setting three gives 3.5 digits and 0.01 line-cycle integration.
// [RQ2] Shortest integration without autozero sustains 300 readings per second.
// [RQ3] Display setting defaults to 5.5 digits after power-on.
// [RQ4] Format code 1 text, 2 packed decimal, 3 timestamped.
// [RQ5] Format selector governs live output only while storage is off.
// [RQ6] Text format: commas between readings, terminator after the last.
// [RQ7] Packed format: three bytes per reading, back to back, no delimiter.
// [RQ8] Timestamped: time of day, CR LF, voltage text, channel number.
// [RQ9] Timestamped: time of day once per trigger, not per reading.
// [RQ10] Timestamped: CR LF only after the group's last channel number.
// [RQ11] Packed reading fits three 8-bit bytes, far below text length.
// [RQ12] Digits: byte one low nibble, then both nibbles of bytes two, three.
// [RQ13] Byte one: bit 4 half digit, bit 5 negative, bits 7:6 exponent plus one.
// [RQ14] Storage mode two keeps stored readings in packed form.
// [RQ15] Storage command without parameter dumps all stored readings.
// [RQ16] Output format defaults to text after power-on.
// [RQ17] On the serial link the line feed is dropped everywhere.
// [RQ18] Timestamped: minus sign before a channel that failed to close.
// [RQ19] Stored output format follows storage mode with text or packed choice.
// [RQ20] Packed digit nibbles hold 0 to 9; bytes go most significant first.
`timescale 1ns/1ps
module rof_formatter #(
  parameter int DEPTH = 60
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // AXI4-Lite write
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [rof_pkg::AW-1:0] awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  // AXI4-Lite read
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [rof_pkg::AW-1:0] araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  // Measurement side
  input  wire logic                   trig,
  input  wire logic [39:0]            tod,
  input  wire logic                   rd_valid,
  output logic                        rd_ready,
  input  wire rof_pkg::rof_reading_t  rd,
  // Byte stream to link
  output logic                        out_valid,
  output logic [7:0]                  out_data,
  input  wire logic                   out_ready,
  // Front end setting
  output logic [2:0]                  digits,
  output logic [6:0]                  integ
);
  import rof_pkg::*;

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || DEPTH > 255) begin : g_bad_depth
    $error("DEPTH must lie in 2..255");
  end
  // Worst byte count of one reading must fit one reading period
  if (BYTES_WORST >= CYC_PER_READ) begin : g_bad_rate
    $error("Clock too slow for the reading rate");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TOD  = 3'h1,
    ST_VOLT = 3'h3,
    ST_CHAN = 3'h2,
    ST_SEP  = 3'h6,
    ST_CR   = 3'h7,
    ST_LF   = 3'h5
  } rof_st_t;

  typedef struct packed {
    rof_st_t       st;
    logic [3:0]    ix;
    logic [1:0]    fmt;
    logic          active;
    logic          dumping;
    logic          tod_pend;
    logic          crlf_tod;
    logic [9:0]    left;
    logic [PW-1:0] ptr;
    logic [7:0]    cnt;
    logic [23:0]   pk;
    logic          fail;
    logic [11:0]   chan;
    logic [39:0]   tod;
    logic          out_valid;
    logic [7:0]    out_data;
    logic          rd_ready;
    rof_ctrl_t     ctrl;
    logic [6:0]    integ;
    logic          aw_ok;
    logic          w_ok;
    logic [AW-1:0] awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } rof_state_t;

  localparam rof_state_t S_RESET = '{st: ST_IDLE, ctrl: CTRL_RESET, integ: INTEG_5,
                                     awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                     default: '0};

  rof_state_t  s;
  rof_state_t  n;
  logic [23:0] mem [DEPTH];
  logic        mem_we;
  logic [23:0] mem_wd;
  logic        adv;
  logic        rd_take;
  logic        storing;
  logic        dump_req;
  logic        done;
  rof_stat_t   stat_w;

  function automatic logic [7:0] dch(logic [3:0] d);
    dch = CH_ZERO + 8'((d > BCD_MAX) ? BCD_MAX : d);
  endfunction : dch

  // Never lets a non-decimal digit nibble onto the link
  function automatic logic [23:0] pack_rd(rof_reading_t r);
    logic [4:0][3:0] d;
    for (int i = 0; i < NUM_DG; i++) begin
      d[i] = (r.dig[i] > BCD_MAX) ? BCD_MAX : r.dig[i]; // [RQ20]
    end
    pack_rd = {r.exp, r.neg, r.half, d}; // [RQ11] [RQ12] [RQ13]
  endfunction : pack_rd

  function automatic logic [6:0] integ_of(logic [2:0] dg);
    case (dg)
      DIG_3:   integ_of = INTEG_3; // [RQ1]
      DIG_4:   integ_of = INTEG_4;
      default: integ_of = INTEG_5;
    endcase
  endfunction : integ_of

  // Illegal codes keep the old setting rather than half-apply
  function automatic rof_ctrl_t ctrl_write(rof_ctrl_t o, logic [31:0] d, logic [3:0] be);
    rof_ctrl_t c;
    for (int i = 0; i < LANES; i++) begin
      c[i*BYTE +: BYTE] = be[i] ? d[i*BYTE +: BYTE] : o[i*BYTE +: BYTE];
    end
    c.rsvd = '0;
    if (c.fmt < FMT_TEXT) c.fmt = o.fmt; // [RQ4]
    if (c.digits < DIG_3 || c.digits > DIG_5) c.digits = o.digits;
    if (c.store > STORE_PACK) c.store = o.store;
    if (c.rpt < RPT_MIN) c.rpt = RPT_MIN;
    else if (c.rpt > RPT_MAX) c.rpt = RPT_MAX;
    ctrl_write = c;
  endfunction : ctrl_write

  function automatic logic [7:0] byte_at(rof_st_t st, logic [3:0] ix, logic [1:0] fmt,
                                         logic [23:0] pk, logic fail, logic [11:0] chan,
                                         logic [39:0] td);
    logic [3:0] k;
    logic [1:0] e;
    k = ix - ix / TOD_GRP;
    e = pk[PK_EXP +: 2];
    byte_at = CH_COMMA;
    case (st)
      ST_TOD: begin
        if (ix % TOD_GRP == TOD_SEP) byte_at = CH_COLON;
        else byte_at = dch(td[int'(TOD_DGMAX - k) * NIB +: NIB]);
      end
      ST_VOLT: begin
        if (fmt == FMT_PACK) begin
          byte_at = pk[int'(PACK_LAST - ix) * BYTE +: BYTE]; // [RQ20]
        end else begin
          case (ix)
            IX_SIGN:  byte_at = pk[PK_NEG] ? CH_MINUS : CH_PLUS;
            IX_HALF:  byte_at = dch(4'(pk[PK_HALF]));
            IX_DOT:   byte_at = CH_DOT;
            IX_E:     byte_at = CH_E;
            IX_ESIGN: byte_at = (e < EXP_UNITY) ? CH_MINUS : CH_PLUS;
            IX_EDIG:  byte_at = dch(4'((e < EXP_UNITY) ? EXP_UNITY - e : e - EXP_UNITY));
            IX_COMMA: byte_at = CH_COMMA;
            default:  byte_at = dch(pk[int'(IX_D5 - ix) * NIB +: NIB]);
          endcase
        end
      end
      ST_CHAN: begin
        if (ix == IX_SIGN) byte_at = fail ? CH_MINUS : CH_PLUS; // [RQ18]
        else byte_at = dch(chan[int'(CHAN_LAST - ix) * NIB +: NIB]);
      end
      ST_CR:   byte_at = CH_CR;
      ST_LF:   byte_at = CH_LF;
      default: byte_at = CH_COMMA;
    endcase
  endfunction : byte_at

  assign adv     = (s.st != ST_IDLE) && (!s.out_valid || out_ready);
  assign rd_take = rd_valid && s.rd_ready;
  assign storing = s.ctrl.store != STORE_OFF; // [RQ5]
  assign mem_wd  = pack_rd(rd); // [RQ14]
  assign stat_w  = '{rsvd: '0, count: s.cnt, rsvd2: '0, busy: s.active};

  always_comb begin
    n        = s;
    mem_we   = 1'b0;
    dump_req = 1'b0;
    done     = 1'b0;
    // Register writes
    if (s.bvalid && bready) n.bvalid = 1'b0;
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      case (s.awaddr)
        ADDR_CTRL:  n.ctrl = ctrl_write(s.ctrl, s.wdata, s.wstrb);
        ADDR_DUMP:  dump_req = 1'b1; // [RQ15]
        ADDR_STAT:  n.bresp = RESP_OKAY;
        ADDR_INTEG: n.bresp = RESP_OKAY;
        default:    n.bresp = RESP_SLVERR;
      endcase
    end
    if (awvalid && s.awready) begin
      n.aw_ok  = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_ok  = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready  = !n.w_ok && !n.bvalid;
    n.integ   = integ_of(n.ctrl.digits); // [RQ1]
    // Register reads
    if (s.rvalid && rready) n.rvalid = 1'b0;
    if (arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      case (araddr)
        ADDR_CTRL:  n.rdata = s.ctrl;
        ADDR_STAT:  n.rdata = stat_w;
        ADDR_DUMP:  n.rdata = '0;
        ADDR_INTEG: n.rdata = 32'(s.integ);
        default: begin
          n.rdata = '0;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;
    // Group start: a dump or a trigger, ignored while busy
    if (!s.active) begin
      if (dump_req && s.cnt != '0) begin
        n.active   = 1'b1;
        n.dumping  = 1'b1;
        n.left     = 10'(s.cnt);
        n.ptr      = '0;
        n.tod_pend = 1'b0;
        n.fmt      = (s.ctrl.store == STORE_PACK) ? FMT_PACK : FMT_TEXT; // [RQ19]
      end else if (trig) begin
        n.active   = 1'b1;
        n.left     = s.ctrl.rpt;
        n.tod      = tod;
        n.fmt      = s.ctrl.fmt; // [RQ5]
        n.tod_pend = (s.ctrl.fmt == FMT_TS) && !storing; // [RQ9]
      end
    end else if (s.st == ST_IDLE) begin
      if (s.dumping) begin
        n.pk   = mem[s.ptr]; // [RQ15]
        n.ptr  = s.ptr + 1'b1;
        n.left = s.left - 1'b1;
        n.st   = ST_VOLT;
        n.ix   = '0;
      end else if (rd_take) begin
        n.left = s.left - 1'b1;
        if (storing) begin
          // A full store drops further readings
          if (s.cnt != 8'(DEPTH)) begin
            mem_we = 1'b1;
            n.cnt  = s.cnt + 1'b1;
          end
          if (n.left == '0) n.active = 1'b0;
        end else begin
          n.pk       = mem_wd;
          n.fail     = rd.fail;
          n.chan     = rd.chan;
          n.st       = s.tod_pend ? ST_TOD : ST_VOLT; // [RQ8] [RQ9]
          n.tod_pend = 1'b0;
          n.ix       = '0;
        end
      end
    end
    // Byte emission
    if (adv) begin
      n.out_valid = 1'b1;
      n.out_data  = byte_at(s.st, s.ix, s.fmt, s.pk, s.fail, s.chan, s.tod);
      n.ix        = s.ix + 1'b1;
      case (s.st)
        ST_TOD: begin
          if (s.ix == TOD_LAST) begin
            n.st       = ST_CR; // [RQ8]
            n.crlf_tod = 1'b1;
          end
        end
        ST_VOLT: begin
          if (s.fmt == FMT_PACK) begin
            if (s.ix == PACK_LAST) done = 1'b1; // [RQ7]
          end else if (s.fmt == FMT_TS) begin
            if (s.ix == IX_COMMA) begin
              n.st = ST_CHAN; // [RQ8]
              n.ix = '0;
            end
          end else if (s.ix == IX_EDIG) begin
            n.st = (s.left != '0) ? ST_SEP : ST_CR; // [RQ6]
          end
        end
        ST_CHAN: begin
          if (s.ix == CHAN_LAST) n.st = (s.left != '0) ? ST_SEP : ST_CR; // [RQ10]
        end
        ST_SEP:  done = 1'b1;
        ST_CR: begin
          if (!s.ctrl.serial) n.st = ST_LF;
          else if (s.crlf_tod) n.st = ST_VOLT; // [RQ17]
          else done = 1'b1;
        end
        ST_LF: begin
          if (s.crlf_tod) n.st = ST_VOLT;
          else done = 1'b1;
        end
        default: done = 1'b1;
      endcase
      if (n.st != s.st) n.ix = '0;
      // Keep the marker through the CR LF pair so the voltage follows
      if (n.st != ST_CR && n.st != ST_LF) n.crlf_tod = 1'b0; // [RQ8]
    end else if (out_ready) begin
      n.out_valid = 1'b0;
    end
    if (done) begin
      n.st = ST_IDLE;
      if (s.left == '0) begin
        n.active  = 1'b0;
        n.dumping = 1'b0;
        if (s.dumping) n.cnt = '0;
      end
    end
    // Storing takes one reading per cycle, far above the top rate
    n.rd_ready = n.active && !n.dumping && n.st == ST_IDLE && n.left != '0; // [RQ2]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s <= S_RESET; // [RQ3] [RQ16]
    end else begin
      s <= n;
    end
  end

  // Store holds no reset; the count marks what is valid
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[s.cnt[PW-1:0]] <= mem_wd; // [RQ14]
    end
  end

  assign awready   = s.awready;
  assign wready    = s.wready;
  assign bvalid    = s.bvalid;
  assign bresp     = s.bresp;
  assign arready   = s.arready;
  assign rvalid    = s.rvalid;
  assign rdata     = s.rdata;
  assign rresp     = s.rresp;
  assign rd_ready  = s.rd_ready;
  assign out_valid = s.out_valid;
  assign out_data  = s.out_data;
  assign digits    = s.ctrl.digits;
  assign integ     = s.integ;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_cr_out;
    adv && s.st == ST_CR;
  endsequence
  sequence s_wr_pair;
    s.aw_ok && s.w_ok && !s.bvalid;
  endsequence

  a_integ_three: assert property ( // [RQ1]
    s.ctrl.digits == DIG_3 |-> s.integ == INTEG_3 && digits == DIG_3)
    else $error("Integration not tied to three-digit setting");
  a_store_rate: assert property ( // [RQ2]
    rd_take && storing && s.left > RPT_MIN |=> s.rd_ready)
    else $error("Storing stalled between readings");
  a_power_on: assert property ( // [RQ3] [RQ16]
    !$past(reset_n) |-> s.ctrl.digits == DIG_5 && s.ctrl.fmt == FMT_TEXT)
    else $error("Wrong power-on settings");
  a_store_quiet: assert property ( // [RQ5]
    rd_take && storing |=> s.st == ST_IDLE)
    else $error("Stored reading went to the link");
  a_text_sep: assert property ( // [RQ6]
    adv && s.st == ST_VOLT && s.fmt == FMT_TEXT && s.ix == IX_EDIG
    |=> s.st == ($past(s.left) == '0 ? ST_CR : ST_SEP))
    else $error("Wrong text separator");
  a_pack_len: assert property ( // [RQ7]
    adv && s.st == ST_VOLT && s.fmt == FMT_PACK && s.ix == PACK_LAST
    |=> s.st == ST_IDLE ##1 s.st != ST_SEP && s.st != ST_CR)
    else $error("Packed reading not three bytes");
  a_pack_digits: assert property ( // [RQ20] [RQ12]
    adv && s.fmt == FMT_PACK |=> s.out_data[3:0] <= BCD_MAX
    && (s.out_data[7:4] <= BCD_MAX || $past(s.ix) == IX_SIGN))
    else $error("Packed nibble out of decimal range");
  a_tod_first: assert property ( // [RQ8]
    rd_take && !storing && s.tod_pend |=> s.st == ST_TOD)
    else $error("Time of day missing at group start");
  a_tod_once: assert property ( // [RQ9]
    rd_take && !storing && s.fmt == FMT_TS && !s.tod_pend |=> s.st == ST_VOLT)
    else $error("Time of day repeated within a group");
  a_crlf_last: assert property ( // [RQ10]
    adv && s.st == ST_CHAN && s.ix == CHAN_LAST
    |=> s.st == ($past(s.left) == '0 ? ST_CR : ST_SEP))
    else $error("Line end not after last channel");
  a_serial_lf: assert property ( // [RQ17]
    s_cr_out ##0 s.ctrl.serial |=> s.st != ST_LF)
    else $error("Line feed sent on serial link");
  a_chan_sign: assert property ( // [RQ18]
    adv && s.st == ST_CHAN && s.ix == IX_SIGN
    |=> out_data == ($past(s.fail) ? CH_MINUS : CH_PLUS))
    else $error("Wrong channel sign");
  a_dump_fmt: assert property ( // [RQ14] [RQ15] [RQ19]
    $rose(s.dumping) |-> s.fmt == (s.ctrl.store == STORE_PACK ? FMT_PACK : FMT_TEXT)
    && s.left == 10'($past(s.cnt)))
    else $error("Dump format or count wrong");
  a_write_answer: assert property (
    s_wr_pair |=> bvalid && !awready && !wready)
    else $error("Write response missing");
endmodule : rof_formatter

//--- logic/rof_pkg.sv
// Constants and carriers of the reading output formatter
package rof_pkg;
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned READ_RATE_HZ = 300;
  localparam int unsigned CYC_PER_READ = CLK_HZ / READ_RATE_HZ;
  localparam int unsigned BYTES_WORST  = 34;
  localparam int AW     = 4;
  localparam int BYTE   = 8;
  localparam int NIB    = 4;
  localparam int LANES  = 4;
  localparam int NUM_DG = 5;

  localparam logic [AW-1:0] ADDR_CTRL  = 4'h0;
  localparam logic [AW-1:0] ADDR_STAT  = 4'h4;
  localparam logic [AW-1:0] ADDR_DUMP  = 4'h8;
  localparam logic [AW-1:0] ADDR_INTEG = 4'hc;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] FMT_TEXT   = 2'h1;
  localparam logic [1:0] FMT_PACK   = 2'h2;
  localparam logic [1:0] FMT_TS     = 2'h3;
  localparam logic [2:0] DIG_3      = 3'h3;
  localparam logic [2:0] DIG_4      = 3'h4;
  localparam logic [2:0] DIG_5      = 3'h5;
  localparam logic [6:0] INTEG_3    = 7'h01;
  localparam logic [6:0] INTEG_4    = 7'h0a;
  localparam logic [6:0] INTEG_5    = 7'h64;
  localparam logic [1:0] STORE_OFF  = 2'h0;
  localparam logic [1:0] STORE_TEXT = 2'h1;
  localparam logic [1:0] STORE_PACK = 2'h2;
  localparam logic [9:0] RPT_MIN    = 10'h001;
  localparam logic [9:0] RPT_MAX    = 10'h3e7;

  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_PLUS  = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT   = 8'h2e;
  localparam logic [7:0] CH_E     = 8'h45;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [3:0] BCD_MAX  = 4'h9;

  localparam logic [3:0] IX_SIGN  = 4'h0;
  localparam logic [3:0] IX_HALF  = 4'h1;
  localparam logic [3:0] IX_DOT   = 4'h2;
  localparam logic [3:0] IX_D5    = 4'h7;
  localparam logic [3:0] IX_E     = 4'h8;
  localparam logic [3:0] IX_ESIGN = 4'h9;
  localparam logic [3:0] IX_EDIG  = 4'ha;
  localparam logic [3:0] IX_COMMA = 4'hb;
  localparam logic [3:0] PACK_LAST = 4'h2;
  localparam logic [3:0] CHAN_LAST = 4'h3;
  localparam logic [3:0] TOD_LAST  = 4'hd;
  localparam logic [3:0] TOD_DGMAX = 4'h9;
  localparam logic [3:0] TOD_GRP   = 4'h3;
  localparam logic [3:0] TOD_SEP   = 4'h2;
  localparam int PK_EXP  = 22;
  localparam int PK_NEG  = 21;
  localparam int PK_HALF = 20;
  localparam logic [1:0] EXP_UNITY = 2'h1;

  typedef struct packed {
    logic [13:0] rsvd;
    logic [9:0]  rpt;
    logic        serial;
    logic [1:0]  store;
    logic [2:0]  digits;
    logic [1:0]  fmt;
  } rof_ctrl_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0]  count;
    logic [6:0]  rsvd2;
    logic        busy;
  } rof_stat_t;

  typedef struct packed {
    logic                neg;
    logic                half;
    logic [1:0]          exp;
    logic [4:0][3:0]     dig;
    logic                fail;
    logic [11:0]         chan;
  } rof_reading_t;

  localparam rof_ctrl_t CTRL_RESET = '{rsvd: '0, rpt: RPT_MIN, serial: 1'b0,
                                       store: STORE_OFF, digits: DIG_5, fmt: FMT_TEXT};
endpackage : rof_pkg

//--- verification/rof_link_model.sv
// Remote controller model that takes the formatter's byte stream
`timescale 1ns/1ps
module rof_link_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Byte stream from the formatter
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  output logic            out_ready
);
  import rof_pkg::*;
  logic [7:0] got_q[$];
  // Random stalls stand in for a slow controller
  // Plain always: the bench empties the queue between tests
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= ($urandom % 4) != 0;
      if (out_valid && out_ready) begin
        got_q.push_back(out_data);
      end
    end
  end
endmodule : rof_link_model

//--- verification/test_reading_output_formatter.sv
// Self-checking bench for the reading output formatter
`timescale 1ns/1ps
module test_reading_output_formatter;
  import rof_pkg::*;
  logic            mclk = 1'b0;
  logic            reset_n = 1'b0;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready, trig, rd_valid, rd_ready;
  logic            out_valid, out_ready;
  logic [AW-1:0]   awaddr, araddr;
  logic [31:0]     wdata, rdata, word;
  logic [3:0]      wstrb;
  logic [1:0]      bresp, rresp, resp;
  logic [39:0]     tod;
  logic [7:0]      out_data;
  logic [2:0]      digits;
  logic [6:0]      integ;
  rof_reading_t    rd;
  rof_reading_t    rs[$];
  logic [7:0]      exp_q[$];
  int              n_mismatch = 0;
  int              num_checks = 0;
  int              cyc = 0;

  always #25 mclk = ~mclk;

  rof_formatter #(.DEPTH(4)) rof_formatter_i (.mclk(mclk), .reset_n(reset_n),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .trig(trig), .tod(tod), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd(rd), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .digits(digits), .integ(integ));
  rof_link_model rof_link_model_i (.mclk(mclk), .reset_n(reset_n), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // Whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rdw(input logic [AW-1:0] a);
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    word = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rdw

  function automatic logic [3:0] cl(input logic [3:0] d);
    return (d > BCD_MAX) ? BCD_MAX : d;
  endfunction : cl

  function automatic logic [7:0] dg(input logic [3:0] d);
    return CH_ZERO | {4'h0, cl(d)};
  endfunction : dg

  function automatic void e_text(input rof_reading_t r);
    exp_q.push_back(r.neg ? CH_MINUS : CH_PLUS);
    exp_q.push_back(dg({3'h0, r.half}));
    exp_q.push_back(CH_DOT);
    for (int i = 4; i >= 0; i--) exp_q.push_back(dg(r.dig[i]));
    exp_q.push_back(CH_E);
    exp_q.push_back(r.exp == 2'h0 ? CH_MINUS : CH_PLUS);
    exp_q.push_back(dg(r.exp == 2'h0 ? 4'h1 : {2'h0, r.exp} - 4'h1));
  endfunction : e_text

  function automatic void e_pack(input rof_reading_t r);
    exp_q.push_back({r.exp, r.neg, r.half, cl(r.dig[4])});
    exp_q.push_back({cl(r.dig[3]), cl(r.dig[2])});
    exp_q.push_back({cl(r.dig[1]), cl(r.dig[0])});
  endfunction : e_pack

  function automatic void e_end(input logic ser);
    exp_q.push_back(CH_CR);
    if (!ser) exp_q.push_back(CH_LF);
  endfunction : e_end

  function automatic rof_reading_t rnd();
    rof_reading_t r;
    r = 37'({$urandom(), $urandom()});
    for (int i = 0; i < 5; i++) r.dig[i] = 4'($urandom % 10);
    for (int i = 0; i < 3; i++) r.chan[i*4 +: 4] = 4'($urandom % 10);
    return r;
  endfunction : rnd

  // Live groups build their expected stream; stored groups leave it for the dump
  task automatic group(input logic [1:0] f, input int n, input logic ser, input logic [1:0] st);
    logic [39:0] t;
    wr(ADDR_CTRL, {14'h0, 10'(n), ser, st, DIG_5, f});
    for (int i = 0; i < 10; i++) t[i*4 +: 4] = 4'($urandom % 10);
    rs.delete();
    for (int i = 0; i < n; i++) rs.push_back(rnd());
    rs[0].dig[0] = 4'hc;
    rs[0].fail = 1'b1;
    if (f == FMT_TS && st == STORE_OFF) begin
      for (int i = 9; i >= 0; i--) begin
        exp_q.push_back(dg(t[i*4 +: 4]));
        if (i % 2 == 0 && i > 0) exp_q.push_back(CH_COLON);
      end
      e_end(ser);
    end
    for (int i = 0; i < n && st == STORE_OFF; i++) begin
      if (f == FMT_PACK) begin
        e_pack(rs[i]);
      end else begin
        e_text(rs[i]);
        if (f == FMT_TS) begin
          exp_q.push_back(CH_COMMA);
          exp_q.push_back(rs[i].fail ? CH_MINUS : CH_PLUS);
          for (int k = 2; k >= 0; k--) exp_q.push_back(dg(rs[i].chan[k*4 +: 4]));
        end
        if (i < n - 1) exp_q.push_back(CH_COMMA);
        else e_end(ser);
      end
    end
    @(posedge mclk);
    trig <= 1'b1;
    tod  <= t;
    @(posedge mclk);
    trig <= 1'b0;
    foreach (rs[i]) begin
      rd       <= rs[i];
      rd_valid <= 1'b1;
      do @(posedge mclk); while (!rd_ready);
    end
    rd_valid <= 1'b0;
  endtask : group

  task automatic check_stream(input string what);
    int k;
    k = 0;
    while (rof_link_model_i.got_q.size() < exp_q.size() && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    repeat (30) @(posedge mclk);
    chk({what, " count"}, exp_q.size(), rof_link_model_i.got_q.size());
    foreach (exp_q[i]) begin
      if (i < rof_link_model_i.got_q.size()) chk(what, exp_q[i], rof_link_model_i.got_q[i]);
    end
    exp_q.delete();
    rof_link_model_i.got_q.delete();
    $display("test %s done", what);
  endtask : check_stream

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, trig, rd_valid} = '0;
    {awaddr, araddr, wdata, tod, rd} = '0;
    wstrb = 4'hf;
    void'($urandom(52));
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk("digits", DIG_5, digits);
    chk("integ", INTEG_5, integ);
    rdw(ADDR_CTRL);
    chk("ctrl", CTRL_RESET, word);
    wr(ADDR_CTRL, {14'h0, 10'h001, 1'b0, STORE_OFF, DIG_3, FMT_TEXT});
    repeat (2) @(posedge mclk);
    chk("digits", DIG_3, digits);
    chk("integ", INTEG_3, integ);
    rdw(ADDR_INTEG);
    chk("integ reg", INTEG_3, word);
    wr(ADDR_CTRL, {14'h0, 10'h001, 1'b0, STORE_OFF, DIG_4, FMT_TEXT});
    rdw(ADDR_INTEG);
    chk("integ four", INTEG_4, word);
    rdw(4'h2);
    chk("unmapped resp", RESP_SLVERR, resp);
    $display("test registers done");
    group(FMT_TEXT, 1 + $urandom % 3, 1'b0, STORE_OFF);
    check_stream("text");
    group(FMT_PACK, 3, 1'b0, STORE_OFF);
    check_stream("packed");
    group(FMT_TS, 2, 1'b0, STORE_OFF);
    check_stream("stamped");
    group(FMT_TEXT, 2, 1'b1, STORE_OFF);
    check_stream("serial");
    group(FMT_TEXT, 2, 1'b0, STORE_PACK);
    check_stream("stored quiet");
    rdw(ADDR_STAT);
    chk("stat", 32'h0000_0200, word);
    foreach (rs[i]) e_pack(rs[i]);
    wr(ADDR_DUMP, 32'h0);
    check_stream("dump");
    rdw(ADDR_STAT);
    chk("stat", 32'h0, word);
    // Five readings into a four-deep store: the last is dropped
    group(FMT_PACK, 5, 1'b0, STORE_TEXT);
    check_stream("stored full");
    rdw(ADDR_STAT);
    chk("stat full", 32'h0000_0400, word);
    for (int i = 0; i < 4; i++) begin
      e_text(rs[i]);
      if (i < 3) exp_q.push_back(CH_COMMA);
      else e_end(1'b0);
    end
    wr(ADDR_DUMP, 32'h0);
    check_stream("text dump");
    stop_test();
  end
endmodule : test_reading_output_formatter
